// File: core/rss_pkg.sv
// shared constants and types for the reset source sequencer
package rss_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_LIVE = 4'hC;
  // cause flag positions, shared by the interrupt status and mask
  localparam int WDT_BIT = 3;
  localparam int BOD_BIT = 2;
  localparam int PIN_BIT = 1;
  localparam int POR_BIT = 0;
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // brown-out level fuse codes
  localparam logic [2:0] BOD_OFF = 3'h7;
  localparam logic [2:0] BOD_1V8 = 3'h6;
  localparam logic [2:0] BOD_2V7 = 3'h5;
  localparam logic [2:0] BOD_4V3 = 3'h4;
  // timing at a 50 ns clock
  localparam int CLK_NS = 50;
  localparam int PIN_MIN_NS = 2500;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int TOUT_BASE_US = 64;
  localparam int TOUT_BASE_CYC = TOUT_BASE_US * 1000 / CLK_NS;
  localparam int CK_STEP_CYC = 6;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_STRETCH = 3'b010,
    ST_RUN = 3'b100
  } rss_state_t;
endpackage

// File: core/rss_cnt_if.sv
// link between the sequencer and its delay counter
`timescale 1ns/100ps
`default_nettype none
interface rss_cnt_if #(parameter int CNT_W = 24);
  logic load;
  logic [CNT_W-1:0] preset;
  logic done;
  modport ctl (output load, output preset, input done);
  modport cnt (input load, input preset, output done);
endinterface
`default_nettype wire

// File: core/rss_sync2.sv
// two-stage synchroniser for pin and detector levels
`timescale 1ns/100ps
`default_nettype none
module rss_sync2 #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else if (aclken)
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: core/rss_stretch.sv
// down counter that stretches the internal reset
`timescale 1ns/100ps
`default_nettype none
module rss_stretch (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // control
  rss_cnt_if.cnt cif
);
  logic [$bits(cif.preset)-1:0] cnt_r;

  // reload whenever a source is active, so a late source restarts the count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= '1;
    else if (aclken)
    begin
      if (cif.load)
        cnt_r <= cif.preset;
      else if (cnt_r != '0)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  assign cif.done = (cnt_r == '0) && !cif.load;
endmodule
`default_nettype wire

// File: core/rss_top.sv
// reset source sequencer: merges reset sources, stretches reset, logs causes
`timescale 1ns/100ps
`default_nettype none
module rss_top
  import rss_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 24,
  parameter int TOUT_CYC = rss_pkg::TOUT_BASE_CYC,
  parameter int CK_CYC = rss_pkg::CK_STEP_CYC,
  parameter int PIN_CYC = rss_pkg::PIN_MIN_CYC
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // reset sources
  input wire logic poweron_ok,
  input wire logic reset_pin_n,
  input wire logic brownout_below,
  input wire logic wdt_expire,
  input wire logic wdt_enable,
  input wire logic wdt_int_enable,
  // fuses
  input wire logic [2:0] brownout_level_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_select_fuses,
  // reset outputs
  output logic io_reset,
  output logic core_reset_n,
  output logic fetch_start,
  output logic [15:0] fetch_addr,
  output logic [2:0] brownout_level_sel,
  output logic irq
);
  rss_state_t state_r, state_nxt;
  logic por_ok_s, pin_n_s, bod_low_s;
  logic [$clog2(PIN_CYC+1)-1:0] pin_cnt_r;
  logic pin_src, bod_en, bod_src, por_src, wdt_fire, wdt_pulse_r;
  logic any_src, src_async;
  logic [3:0] src_vec, src_d_r, src_rise;
  logic [7:0] cause_r, cause_nxt;
  logic [3:0] irq_stat_r, irq_stat_nxt, irq_mask_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0] wr_strb_r;
  logic aw_got_r, w_got_r, aw_take, w_take, wr_go, ar_take;
  logic aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
  logic wr_hit, rd_hit, cause_wr, mask_wr, stat_rd;
  logic [31:0] rd_mux;
  logic [CNT_W-1:0] base_w;

  rss_cnt_if #(.CNT_W(CNT_W)) cif ();

  // detector and pin levels come from outside the clock domain
  rss_sync2 #(.W(3), .RST_VAL(SYNC_RST)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .d({bod_low_s_in(brownout_below), reset_pin_n, poweron_ok}),
    .q({bod_low_s, pin_n_s, por_ok_s})
  );

  rss_stretch u_stretch (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .cif(cif)
  );

  function automatic logic bod_low_s_in(input logic v);
    bod_low_s_in = v;
  endfunction

  // power-on source is active while supply sits below the threshold
  assign por_src = !por_ok_s;

  // pin low must persist for the minimum width before it counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_cnt_r <= '0;
    else if (aclken)
    begin
      if (pin_n_s)
        pin_cnt_r <= '0;
      else if (!pin_src)
        pin_cnt_r <= pin_cnt_r + 1'b1;
    end
  end

  assign pin_src = (pin_cnt_r == ($bits(pin_cnt_r))'(PIN_CYC));

  // reserved codes leave the detector disabled
  assign bod_en = (brownout_level_fuses == BOD_1V8) || (brownout_level_fuses == BOD_2V7)
    || (brownout_level_fuses == BOD_4V3);
  assign bod_src = bod_en && bod_low_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      brownout_level_sel <= 3'h0;
    else if (aclken)
    begin
      case (brownout_level_fuses)
        BOD_1V8: brownout_level_sel <= 3'h1;
        BOD_2V7: brownout_level_sel <= 3'h2;
        BOD_4V3: brownout_level_sel <= 3'h4;
        default: brownout_level_sel <= 3'h0;
      endcase
    end
  end

  // watchdog only resets in pure reset mode
  assign wdt_fire = wdt_expire && wdt_enable && !wdt_int_enable;

  // never wider than one cycle, even if expire is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdt_pulse_r <= 1'b0;
    else if (aclken)
      wdt_pulse_r <= wdt_fire && !wdt_pulse_r;
  end

  assign src_vec = {wdt_pulse_r, bod_src, pin_src, por_src};
  assign any_src = |src_vec;

  // preset grows with both fuse fields
  assign base_w = CNT_W'(TOUT_CYC);
  assign cif.preset = (base_w << startup_time_fuses)
    + CNT_W'(CK_CYC * int'(clock_select_fuses));
  assign cif.load = any_src;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_HOLD:
      begin
        if (!any_src)
          state_nxt = ST_STRETCH;
      end
      ST_STRETCH:
      begin
        if (any_src)
          state_nxt = ST_HOLD;
        else if (cif.done)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (any_src)
          state_nxt = ST_HOLD;
      end
      default: state_nxt = ST_HOLD;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= ST_HOLD;
    else if (aclken)
      state_r <= state_nxt;
  end

  // release the core and start fetching at the vector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_reset_n <= 1'b0;
      fetch_start <= 1'b0;
      fetch_addr <= RESET_VECTOR;
    end
    else if (aclken)
    begin
      core_reset_n <= (state_nxt == ST_RUN);
      fetch_start <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
      fetch_addr <= RESET_VECTOR;
    end
  end

  // raw levels bypass the synchroniser so ports clear with no clock running;
  // short pin glitches may therefore clear the ports without a core reset
  assign src_async = !poweron_ok || !reset_pin_n || (bod_en && brownout_below);

  always_ff @(posedge aclk or posedge src_async)
  begin
    if (src_async)
      io_reset <= 1'b1;
    else if (!aresetn)
      io_reset <= 1'b1;
    else if (aclken)
      io_reset <= (state_nxt != ST_RUN);
  end

  // axi write channel handshakes
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_go = aw_got_r && w_got_r && !bvalid;
  assign aw_got_nxt = wr_go ? 1'b0 : (aw_got_r || aw_take);
  assign w_got_nxt = wr_go ? 1'b0 : (w_got_r || w_take);
  assign bvalid_nxt = wr_go || (bvalid && !bready);
  assign wr_hit = (wr_addr_r[ADDR_W-1:4] == '0) && (wr_addr_r[1:0] == 2'h0);
  assign cause_wr = wr_go && wr_hit && (wr_addr_r[3:0] == ADDR_CAUSE) && wr_strb_r[0];
  assign mask_wr = wr_go && wr_hit && (wr_addr_r[3:0] == ADDR_IRQ_MASK) && wr_strb_r[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr_r <= '0;
      wr_data_r <= 32'h0;
      wr_strb_r <= 4'h0;
    end
    else if (aclken)
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready <= !aw_got_nxt && !bvalid_nxt;
      wready <= !w_got_nxt && !bvalid_nxt;
      bvalid <= bvalid_nxt;
      if (aw_take)
        wr_addr_r <= awaddr;
      if (w_take)
      begin
        wr_data_r <= wdata;
        wr_strb_r <= wstrb;
      end
      if (wr_go)
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // axi read channel
  assign ar_take = arvalid && arready;
  assign rvalid_nxt = ar_take || (rvalid && !rready);
  assign rd_hit = (araddr[ADDR_W-1:4] == '0) && (araddr[1:0] == 2'h0);
  assign stat_rd = ar_take && rd_hit && (araddr[3:0] == ADDR_IRQ_STAT);

  always_comb
  begin
    rd_mux = 32'h0;
    case (araddr[3:0])
      ADDR_CAUSE: rd_mux = {24'h0, cause_r};
      ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
      ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
      ADDR_LIVE: rd_mux = {24'h0, brownout_level_sel, !core_reset_n, src_vec};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end
    else if (aclken)
    begin
      arready <= !rvalid_nxt;
      rvalid <= rvalid_nxt;
      if (ar_take)
      begin
        rdata <= rd_hit ? rd_mux : 32'h0;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // cause flags: software clears by writing zero; hardware set wins
  always_comb
  begin
    cause_nxt = cause_r;
    if (cause_wr)
      cause_nxt[3:0] = cause_r[3:0] & wr_data_r[3:0];
    if (por_src)
    begin
      cause_nxt[WDT_BIT] = 1'b0;
      cause_nxt[BOD_BIT] = 1'b0;
      cause_nxt[PIN_BIT] = 1'b0;
      cause_nxt[POR_BIT] = 1'b1;
    end
    else
    begin
      if (wdt_pulse_r)
        cause_nxt[WDT_BIT] = 1'b1;
      if (bod_src)
        cause_nxt[BOD_BIT] = 1'b1;
      if (pin_src)
        cause_nxt[PIN_BIT] = 1'b1;
    end
    cause_nxt[7:4] = 4'h0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cause_r <= CAUSE_RST;
    else if (aclken)
      cause_r <= cause_nxt;
  end

  // interrupt on each source's onset; a read clears, a new onset wins
  assign src_rise = src_vec & ~src_d_r;

  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (stat_rd)
      irq_stat_nxt = 4'h0;
    irq_stat_nxt = irq_stat_nxt | src_rise;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_d_r <= 4'h0;
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      irq <= 1'b0;
    end
    else if (aclken)
    begin
      src_d_r <= src_vec;
      irq_stat_r <= irq_stat_nxt;
      if (mask_wr)
        irq_mask_r <= wr_data_r[3:0];
      irq <= |(irq_stat_nxt & (mask_wr ? wr_data_r[3:0] : irq_mask_r));
    end
  end
endmodule
`default_nettype wire

// File: tb/rss_assertions.sv
// port-level assertions for the reset source sequencer
`timescale 1ns/100ps
`default_nettype none
module rss_assertions
  import rss_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sources and fuses
  input wire logic poweron_ok,
  input wire logic reset_pin_n,
  input wire logic wdt_expire,
  input wire logic wdt_enable,
  input wire logic wdt_int_enable,
  input wire logic [2:0] brownout_level_fuses,
  // reset outputs
  input wire logic io_reset,
  input wire logic core_reset_n,
  input wire logic fetch_start,
  input wire logic [15:0] fetch_addr,
  input wire logic [2:0] brownout_level_sel
);
  logic [2:0] exp_sel;
  always_comb
  begin
    case (brownout_level_fuses)
      BOD_1V8: exp_sel = 3'h1;
      BOD_2V7: exp_sel = 3'h2;
      BOD_4V3: exp_sel = 3'h4;
      default: exp_sel = 3'h0;
    endcase
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the decode register lags a fuse change, so judge it only once settled
  sequence s_fuse_settled;
    $stable(brownout_level_fuses) [*3];
  endsequence
  sequence s_wdt_armed;
    wdt_expire && wdt_enable && !wdt_int_enable && core_reset_n;
  endsequence
  property p_fetch; fetch_start |-> $rose(core_reset_n); endproperty
  property p_vector; fetch_start |-> fetch_addr == RESET_VECTOR; endproperty
  property p_io; (!poweron_ok || !reset_pin_n) |-> io_reset; endproperty
  property p_por_drop; $fell(poweron_ok) |-> ##[1:3] !core_reset_n; endproperty
  property p_stretch;
    $rose(core_reset_n) |-> $past(poweron_ok, 4) && $past(reset_pin_n, 4);
  endproperty
  property p_wdt; s_wdt_armed |-> ##[1:3] !core_reset_n; endproperty
  property p_wdt_ign;
    wdt_expire && !(wdt_enable && !wdt_int_enable) && core_reset_n |=> core_reset_n;
  endproperty
  property p_bod_sel; s_fuse_settled |-> brownout_level_sel == exp_sel; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch strobe without release");
  a_vector: assert property (p_vector) else $error("fetch address wrong");
  a_io: assert property (p_io) else $error("io reset not forced");
  a_por_drop: assert property (p_por_drop) else $error("supply loss not seen");
  a_stretch: assert property (p_stretch) else $error("release too early");
  a_wdt: assert property (p_wdt) else $error("watchdog reset missing");
  a_wdt_ign: assert property (p_wdt_ign) else $error("watchdog not gated");
  a_bod_sel: assert property (p_bod_sel) else $error("level decode wrong");
endmodule
bind rss_top rss_assertions u_chk (.aclk, .aresetn, .poweron_ok, .reset_pin_n, .wdt_expire,
  .wdt_enable, .wdt_int_enable, .brownout_level_fuses, .io_reset, .core_reset_n,
  .fetch_start, .fetch_addr, .brownout_level_sel);
`default_nettype wire

// File: tb/rss_far_side.sv
// supply detectors, reset pin and watchdog facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module rss_far_side (
  // clock
  input wire logic aclk,
  // source levels
  output logic poweron_ok,
  output logic reset_pin_n,
  output logic brownout_below,
  output logic wdt_expire,
  output logic wdt_enable,
  output logic wdt_int_enable
);
  initial
  begin
    poweron_ok = 1'b0;
    reset_pin_n = 1'b1;
    brownout_below = 1'b0;
    wdt_expire = 1'b0;
    wdt_enable = 1'b0;
    wdt_int_enable = 1'b0;
  end
  // supply ramps reduced to level steps; no hysteresis modelled
  task automatic supply(input logic ok, input logic below);
    @(posedge aclk);
    poweron_ok <= ok;
    brownout_below <= below;
  endtask
  task automatic pin_low(input int n);
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge aclk);
    reset_pin_n <= 1'b1;
  endtask
  // mode bits settle a cycle ahead of the time-out strobe
  task automatic wdt_fire(input logic en, input logic ie);
    @(posedge aclk);
    wdt_enable <= en;
    wdt_int_enable <= ie;
    @(posedge aclk);
    wdt_expire <= 1'b1;
    @(posedge aclk);
    wdt_expire <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_reset_source_sequencer.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_reset_source_sequencer;
  import rss_pkg::*;
  localparam int TOUT = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, io_reset, core_reset_n, fetch_start, irq;
  logic poweron_ok, reset_pin_n, brownout_below, wdt_expire, wdt_enable, wdt_int_enable;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] fetch_addr;
  logic [2:0] bod_fuse = BOD_OFF, brownout_level_sel;
  logic [1:0] stf = 2'h0;
  logic [3:0] csf = 4'h0, wstrb_v = 4'hF;
  int errors = 0, samples_checked = 0, cycles = 0;
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  rss_far_side u_far (.aclk, .poweron_ok, .reset_pin_n, .brownout_below, .wdt_expire,
    .wdt_enable, .wdt_int_enable);
  // short counts keep each stretch to a handful of cycles: preset is 4 with both fuse fields at zero, 10 once t_por sets them
  rss_top #(.TOUT_CYC(TOUT), .CK_CYC(1), .PIN_CYC(3)) uut (.aclk, .aresetn,
    .aclken(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb(wstrb_v), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .poweron_ok, .reset_pin_n, .brownout_below, .wdt_expire, .wdt_enable, .wdt_int_enable,
    .brownout_level_fuses(bod_fuse), .startup_time_fuses(stf), .clock_select_fuses(csf),
    .io_reset, .core_reset_n, .fetch_start, .fetch_addr, .brownout_level_sel, .irq);
  task automatic summarize();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("FAIL %0t timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    #1;
    while (awvalid || wvalid)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      #1;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
    rd_reg(a);
    chk(rd, exp, msg);
  endtask
  // counts cycles until the core leaves reset, then judges the release
  task automatic rel(input int lo);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    while (core_reset_n !== 1'b1);
    chk(n >= lo && n <= lo + 12, 1'b1, "stretch length");
    chk(fetch_start, 1'b1, "no fetch strobe");
    chk(fetch_addr, RESET_VECTOR, "fetch address");
  endtask
  // lo is the expected preset for the fuse settings in force
  task automatic power_cycle(input int lo);
    u_far.supply(1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    #1;
    chk(core_reset_n, 1'b0, "supply loss");
    chk(io_reset, 1'b1, "io held");
    u_far.supply(1'b1, 1'b0);
    rel(lo);
  endtask
  task automatic t_por();
    chk(io_reset, 1'b1, "io not held");
    u_far.supply(1'b1, 1'b0);
    rel(TOUT);
    rchk(ADDR_CAUSE, 32'h01, "power-on flag");
    wr(ADDR_CAUSE, 32'h0);
    rchk(ADDR_CAUSE, 32'h00, "power-on flag clear");
    // doubled base plus two clock steps: preset becomes 2*TOUT+2
    stf <= 2'h1;
    csf <= 4'h2;
    power_cycle(2 * TOUT + 2);
    rchk(ADDR_CAUSE, 32'h01, "power-on flag again");
    wr(ADDR_CAUSE, 32'h0);
  endtask
  task automatic t_pin();
    u_far.pin_low(1);
    repeat (6) @(posedge aclk);
    #1;
    chk(core_reset_n, 1'b1, "short pulse");
    rd_reg(ADDR_IRQ_STAT);
    wr(ADDR_IRQ_MASK, 32'h02);
    u_far.pin_low(8);
    #1;
    chk(core_reset_n, 1'b0, "pin reset");
    // a second low lands inside the stretch and must restart it
    u_far.pin_low(6);
    #1;
    chk(core_reset_n, 1'b0, "restart held");
    rel(TOUT);
    chk(irq, 1'b1, "irq raise");
    rchk(ADDR_IRQ_STAT, 32'h02, "irq status");
    @(posedge aclk);
    #1;
    chk(irq, 1'b0, "irq read clear");
    rchk(ADDR_CAUSE, 32'h02, "pin flag");
    wr(ADDR_CAUSE, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
  endtask
  task automatic t_wdt();
    for (int m = 0; m < 3; m++)
    begin
      u_far.wdt_fire(m == 2, m != 0);
      repeat (4) @(posedge aclk);
      #1;
      chk(core_reset_n, 1'b1, "watchdog gated");
    end
    u_far.wdt_fire(1'b1, 1'b0);
    repeat (3) @(posedge aclk);
    #1;
    chk(core_reset_n, 1'b0, "watchdog reset");
    chk(irq, 1'b0, "masked irq");
    rel(1);
    rchk(ADDR_CAUSE, 32'h08, "watchdog flag");
    // a write without its low byte strobe must leave the flags alone
    wstrb_v <= 4'h0;
    wr(ADDR_CAUSE, 32'h0);
    rchk(ADDR_CAUSE, 32'h08, "strobe off write");
    wstrb_v <= 4'hF;
    wr(ADDR_CAUSE, 32'h0);
    rchk(ADDR_CAUSE, 32'h00, "watchdog flag clear");
  endtask
  task automatic t_bod();
    logic [2:0] sel;
    for (int f = 7; f >= 0; f--)
    begin
      @(posedge aclk);
      bod_fuse <= 3'(f);
      repeat (4) @(posedge aclk);
      #1;
      sel = (f == 6) ? 3'h1 : (f == 5) ? 3'h2 : (f == 4) ? 3'h4 : 3'h0;
      chk(brownout_level_sel, sel, "level decode");
      u_far.supply(1'b1, 1'b1);
      repeat (4) @(posedge aclk);
      #1;
      chk(core_reset_n, sel == 3'h0, "brown-out gating");
      u_far.supply(1'b1, 1'b0);
      if (core_reset_n !== 1'b1)
        rel(TOUT);
    end
    rchk(ADDR_CAUSE, 32'h04, "brown-out flag");
    power_cycle(2 * TOUT + 2);
    rchk(ADDR_CAUSE, 32'h01, "power-on clears flags");
    rchk(ADDR_LIVE, 32'h00, "live status");
    rd_reg(32'h10);
    chk(rr, RESP_SLVERR, "unmapped response");
    chk(rd, 32'h0, "unmapped data");
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_por();
    t_pin();
    t_wdt();
    t_bod();
    summarize();
  end
endmodule
`default_nettype wire
